// File: src/sfc_frame_check.v
// Serial frame receiver with optional CRC-8 check and fault output
`timescale 1ns/10ps
`include "sfc_regs.vh"
module sfc_frame_check (
    input wire i_sys_clk,
    input wire i_sys_rst,
    input wire i_sclk,
    input wire i_sdin,
    input wire i_sync_n,
    input wire [2:0] i_rd_addr,
    input wire i_rd_req,
    output reg o_fault_out,
    output reg o_fault_oe,
    output reg o_crc_error_flag,
    output reg [15:0] o_rd_data,
    output reg o_rd_valid,
    output reg o_wr_pulse,
    output reg [15:0] o_wr_word
);
    localparam ST_IDLE = 3'b001;
    localparam ST_SHIFT = 3'b010;
    localparam ST_CHECK = 3'b100;

    // One CRC-8 step, MSB first
    function [7:0] crc_step;
        input [7:0] crc;
        input bitin;
        begin
            if (crc[7] ^ bitin) begin
                crc_step = {crc[6:0], 1'b0} ^ `SFC_CRC_POLY;
            end else begin
                crc_step = {crc[6:0], 1'b0};
            end
        end
    endfunction

    // Address field of a command word; shared by both frame lengths
    function [2:0] cmd_addr;
        input [15:0] word;
        begin
            cmd_addr = word[`SFC_ADDR_MSB:`SFC_ADDR_LSB];
        end
    endfunction

    // Status word: only the CRC error bit is live, the rest read zero
    function [15:0] status_word;
        input err;
        begin
            status_word = 16'h0000;
            status_word[`SFC_STAT_CRC_BIT] = err;
        end
    endfunction

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg sclk_d_reg;
    reg sync_d_reg;
    reg [23:0] shift_reg;
    reg [4:0] count_reg;
    reg [7:0] crc_reg;
    reg err_reg;
    reg we_reg;
    reg [2:0] waddr_reg;
    reg [15:0] wdata_reg;
    reg rd_pend_reg;
    reg rd_status_reg;
    wire [15:0] mem_rdata;
    wire sclk_fall;
    wire sync_rise;
    wire sync_fall;
    wire frame_ok16;
    wire frame_ok24;
    wire crc_match;
    wire frame_end;
    wire crc_fail;

    // Inputs taken as synchronous; edges found against last sample
    assign sclk_fall = sclk_d_reg & ~i_sclk;
    assign sync_rise = ~sync_d_reg & i_sync_n;
    assign sync_fall = sync_d_reg & ~i_sync_n;
    assign frame_ok16 = (count_reg == 5'h10);
    assign frame_ok24 = (count_reg == 5'h18);
    assign crc_match = (crc_reg == shift_reg[7:0]);
    assign frame_end = (state_reg == ST_CHECK);
    assign crc_fail = frame_end && frame_ok24 && !crc_match;

    // Frame end counts only in SHIFT; a stray rise in IDLE is ignored
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (sync_fall) begin
                    state_next = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (sync_rise) begin
                    state_next = ST_CHECK;
                end
            end
            ST_CHECK: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
            // Idle-high history so reset release shows no false edge
            sclk_d_reg <= 1'b1;
            sync_d_reg <= 1'b1;
            shift_reg <= 24'h000000;
            count_reg <= 5'h00;
            crc_reg <= `SFC_CRC_INIT;
            err_reg <= 1'b0;
            we_reg <= 1'b0;
            waddr_reg <= 3'h0;
            wdata_reg <= 16'h0000;
        end else begin
            sclk_d_reg <= i_sclk;
            sync_d_reg <= i_sync_n;
            state_reg <= state_next;
            we_reg <= 1'b0;
            if (state_reg == ST_IDLE && sync_fall) begin
                count_reg <= 5'h00;
                crc_reg <= `SFC_CRC_INIT;
            end
            if (state_reg == ST_SHIFT && !i_sync_n && sclk_fall) begin
                shift_reg <= {shift_reg[22:0], i_sdin};
                // Saturate so overlong frames never alias to a legal length
                if (count_reg != 5'h1F) begin
                    count_reg <= count_reg + 5'h01;
                end
                if (count_reg < 5'h10) begin
                    crc_reg <= crc_step(crc_reg, i_sdin);
                end
            end
            // Count settled a cycle ago, so the length test is clean here
            if (frame_end) begin
                if (frame_ok16) begin
                    we_reg <= 1'b1;
                    waddr_reg <= cmd_addr(shift_reg[15:0]);
                    wdata_reg <= shift_reg[15:0];
                end else if (frame_ok24) begin
                    if (crc_match) begin
                        we_reg <= 1'b1;
                        waddr_reg <= cmd_addr(shift_reg[23:8]);
                        wdata_reg <= shift_reg[23:8];
                    end
                end
            end
            // Set wins over a clearing status read in the same cycle
            if (crc_fail) begin
                err_reg <= 1'b1;
            end else if (rd_status_reg) begin
                err_reg <= 1'b0;
            end
        end
    end

    // Store written a cycle after the decision so outputs stay registered
    sfc_regmem u_mem (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_we(we_reg),
        .i_waddr(waddr_reg),
        .i_wdata(wdata_reg),
        .i_raddr(i_rd_addr),
        .o_rdata(mem_rdata)
    );

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rd_pend_reg <= 1'b0;
            rd_status_reg <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 16'h0000;
            o_fault_out <= 1'b0;
            o_fault_oe <= 1'b0;
            o_crc_error_flag <= 1'b0;
            o_wr_pulse <= 1'b0;
            o_wr_word <= 16'h0000;
        end else begin
            rd_pend_reg <= i_rd_req;
            rd_status_reg <= i_rd_req && (i_rd_addr == `SFC_STATUS_ADDR);
            o_rd_valid <= rd_pend_reg;
            if (rd_pend_reg) begin
                // Status answers from the live bit, not the store
                if (rd_status_reg) begin
                    o_rd_data <= status_word(err_reg);
                end else begin
                    o_rd_data <= mem_rdata;
                end
            end
            // Open drain: never drive high, only enable to pull low
            o_fault_out <= 1'b0;
            o_fault_oe <= err_reg;
            o_crc_error_flag <= err_reg;
            o_wr_pulse <= we_reg;
            if (we_reg) begin
                o_wr_word <= wdata_reg;
            end
        end
    end
endmodule // sfc_frame_check

// File: src/sfc_regs.vh
// Constants for the serial frame CRC-8 check block
`ifndef SFC_REGS_VH
`define SFC_REGS_VH
`define SFC_WORD_BITS 16
`define SFC_FRAME_BITS 24
`define SFC_CRC_POLY 8'h07
`define SFC_CRC_INIT 8'h00
`define SFC_ADDR_MSB 15
`define SFC_ADDR_LSB 13
`define SFC_NUM_REGS 8
`define SFC_STATUS_ADDR 3'h7
`define SFC_STAT_CRC_BIT 3
`endif

// File: src/sfc_regmem.v
// Small register store addressed by the command address bits
`timescale 1ns/10ps
module sfc_regmem (
    input wire i_sys_clk,
    input wire i_sys_rst,
    input wire i_we,
    input wire [2:0] i_waddr,
    input wire [15:0] i_wdata,
    input wire [2:0] i_raddr,
    output reg [15:0] o_rdata
);
    reg [15:0] mem_reg [0:7];
    integer k;
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            for (k = 0; k < 8; k = k + 1) begin
                mem_reg[k] <= 16'h0000;
            end
            o_rdata <= 16'h0000;
        end else begin
            if (i_we) begin
                mem_reg[i_waddr] <= i_wdata;
            end
            o_rdata <= mem_reg[i_raddr];
        end
    end
endmodule // sfc_regmem

// File: tb/sfc_frame_check_checker.sv
// Assertion checker for the serial frame CRC check block
`timescale 1ns/10ps
module sfc_checker (
    input wire i_sys_clk, i_sys_rst, i_sclk, i_sdin, i_sync_n, i_rd_req,
    input wire [2:0] i_rd_addr,
    input wire o_fault_out, o_fault_oe, o_crc_error_flag, o_rd_valid, o_wr_pulse,
    input wire [15:0] o_rd_data, o_wr_word
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    a_rd_latency: assert property (i_rd_req |-> ##2 o_rd_valid)
        else $error("read answer late");
    a_fault_drain: assert property (!o_fault_out)
        else $error("fault data high");
    a_flag_oe_tie: assert property (o_fault_oe == o_crc_error_flag)
        else $error("fault and flag differ");
    a_wr_on_rise: assert property (o_wr_pulse |-> $past(i_sync_n, 3) && !$past(i_sync_n, 4))
        else $error("write without frame end");
    a_err_cause: assert property ($rose(o_crc_error_flag) |-> !o_wr_pulse && $past(i_sync_n, 3))
        else $error("error without frame end");
    a_wr_single: assert property (o_wr_pulse |=> !o_wr_pulse)
        else $error("write pulse too long");
    a_status_clr: assert property (i_rd_req && i_rd_addr == 3'h7 && i_sync_n && $past(i_sync_n) |-> ##3 !o_fault_oe)
        else $error("fault not released");
    a_status_word: assert property (o_rd_valid && $past(i_rd_addr, 2) == 3'h7 |->
        o_rd_data == {12'h000, o_crc_error_flag, 3'h0})
        else $error("status word wrong");
    c_write: cover property (o_wr_pulse);
    c_err_read: cover property (o_rd_valid && o_rd_data[3]);
    c_release: cover property ($fell(o_fault_oe));
endmodule // sfc_checker
bind sfc_frame_check sfc_checker chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_sclk(i_sclk),
    .i_sdin(i_sdin), .i_sync_n(i_sync_n), .i_rd_req(i_rd_req), .i_rd_addr(i_rd_addr),
    .o_fault_out(o_fault_out), .o_fault_oe(o_fault_oe), .o_crc_error_flag(o_crc_error_flag),
    .o_rd_valid(o_rd_valid), .o_wr_pulse(o_wr_pulse), .o_rd_data(o_rd_data), .o_wr_word(o_wr_word));

// File: tb/sfc_host.sv
// Host serial port model sending framed command words
`timescale 1ns/10ps
module sfc_host (
    input wire i_clk,
    output logic o_sclk,
    output logic o_sdin,
    output logic o_sync_n
);
    initial begin
        o_sclk = 1'b1;
        o_sdin = 1'b0;
        o_sync_n = 1'b1;
    end
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic tk(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Bad frames flip the check byte LSB; n of 16 drops the byte
    task automatic send(input logic [15:0] w, input int n, input logic bad);
        logic [23:0] f;
        f = {w, crc8(w) ^ {7'h00, bad}};
        o_sync_n = 1'b0;
        tk(2);
        for (int i = 23; i > 23 - n; i--) begin
            o_sclk = 1'b1;
            o_sdin = f[i];
            tk(2);
            o_sclk = 1'b0;
            tk(2);
        end
        o_sclk = 1'b1;
        o_sync_n = 1'b1;
        o_sdin = ~o_sdin; // Data line inverted from the last bit sent
    endtask
endmodule // sfc_host

// File: tb/test_serial_frame_crc8_check.sv
// Self-checking bench for the serial frame CRC check block
`timescale 1ns/10ps
module test_serial_frame_crc8_check;
    logic i_sys_clk, i_sys_rst, i_rd_req;
    logic [2:0] i_rd_addr;
    wire i_sclk, i_sdin, i_sync_n, o_fault_out, o_fault_oe, o_crc_error_flag, o_rd_valid, o_wr_pulse;
    wire [15:0] o_rd_data, o_wr_word;
    wire fault_line = o_fault_oe ? 1'b0 : 1'b1;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    sfc_host host (.i_clk(i_sys_clk), .o_sclk(i_sclk), .o_sdin(i_sdin), .o_sync_n(i_sync_n));
    sfc_frame_check uut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_sclk(i_sclk), .i_sdin(i_sdin),
        .i_sync_n(i_sync_n), .i_rd_addr(i_rd_addr), .i_rd_req(i_rd_req), .o_fault_out(o_fault_out),
        .o_fault_oe(o_fault_oe), .o_crc_error_flag(o_crc_error_flag), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .o_wr_pulse(o_wr_pulse), .o_wr_word(o_wr_word));
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    task automatic close_out;
        if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Fixed two-cycle read answer
    task automatic rd(input logic [2:0] a);
        i_rd_addr = a;
        i_rd_req = 1'b1;
        host.tk(1);
        i_rd_req = 1'b0;
        host.tk(1);
        chk(o_rd_valid, 16'h1, "read valid");
        host.tk(1);
    endtask
    task automatic t_raw_word;
        host.send(16'hA5C3, 16, 1'b0);
        host.tk(3);
        chk(o_wr_pulse, 16'h1, "raw pulse");
        chk(o_wr_word, 16'hA5C3, "raw word");
        rd(3'h5);
        chk(o_rd_data, 16'hA5C3, "raw store");
    endtask
    task automatic t_good_crc;
        host.send(16'h3C96, 24, 1'b0);
        host.tk(3);
        chk(o_wr_pulse, 16'h1, "crc pulse");
        rd(3'h1);
        chk(o_rd_data, 16'h3C96, "crc store");
        host.send(16'h2BAD, 20, 1'b0);
        host.tk(3);
        chk(o_wr_pulse, 16'h0, "odd pulse");
        chk(o_crc_error_flag, 16'h0, "odd flag");
    endtask
    task automatic t_bad_crc;
        host.send(16'h2BAD, 24, 1'b1);
        host.tk(3);
        chk(o_wr_pulse, 16'h0, "bad pulse");
        chk(fault_line, 16'h0, "fault line");
        rd(3'h1);
        chk(o_rd_data, 16'h3C96, "kept store");
        rd(3'h7);
        chk(o_rd_data, 16'h0008, "status");
        host.tk(1);
        chk(fault_line, 16'h1, "released");
        chk(o_crc_error_flag, 16'h0, "flag");
    endtask
    // Ceiling well above the four short frames
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        i_sys_rst = 1'b1;
        i_rd_req = 1'b0;
        i_rd_addr = 3'h0;
        host.tk(12);
        i_sys_rst = 1'b0;
        t_raw_word();
        t_good_crc();
        t_bad_crc();
        close_out();
    end
endmodule // test_serial_frame_crc8_check
